/* File: hw/rtt_pkg.sv */
package rtt_pkg;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_T3_CTRL = 7'h1e;
  localparam logic [6:0] IDX_T3_RLD_HI = 7'h1f;
  localparam logic [6:0] IDX_T3_RLD_LO = 7'h20;
  localparam logic [6:0] IDX_T3_CNT_HI = 7'h21;
  localparam logic [6:0] IDX_T3_CNT_LO = 7'h22;
  localparam logic [6:0] IDX_WK_CTRL = 7'h23;
  localparam logic [6:0] IDX_WK_RLD_HI = 7'h24;
  localparam logic [6:0] IDX_WK_RLD_LO = 7'h25;
  localparam logic [6:0] IDX_WK_CNT_HI = 7'h26;
  localparam logic [6:0] IDX_WK_CNT_LO = 7'h27;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h28;
  localparam logic [6:0] IDX_IRQ_EN = 7'h29;
  localparam logic [6:0] IDX_IRQ_CLR = 7'h2a;

  // general timer control fields
  localparam int T3_STOP_RX_BIT = 7;
  localparam int T3_START_LSB = 4;
  localparam int T3_RESTART_BIT = 3;
  localparam int T3_CLK_LSB = 0;
  localparam logic [7:0] T3_CTRL_WMASK = 8'hbb;

  // wake timer control fields
  localparam int WK_RUN_BIT = 7;
  localparam int WK_RWE_BIT = 6;
  localparam int WK_TRIM_BIT = 5;
  localparam int WK_LOW_POWER_CARD_DETECTION_BIT = 4;
  localparam int WK_RESTART_BIT = 3;
  localparam int WK_WAKE_BIT = 2;
  localparam int WK_CLK_LSB = 0;

  // interrupt status layout
  localparam int IRQ_T3_BIT = 0;
  localparam int IRQ_WK_BIT = 1;

  // reset values
  localparam logic [7:0] T3_CTRL_RST = 8'h00;
  localparam logic [5:0] WK_CTRL_RST = 6'h00;
  localparam logic [15:0] RLD_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // wake timer prescaler terminal counts (divide by 1, 8, 16, 32)
  localparam logic [4:0] WK_DIV1_TC = 5'h00;
  localparam logic [4:0] WK_DIV8_TC = 5'h07;
  localparam logic [4:0] WK_DIV16_TC = 5'h0f;
  localparam logic [4:0] WK_DIV32_TC = 5'h1f;

  typedef enum logic [1:0] {
    START_OFF = 2'b00,
    START_TX_END = 2'b01,
    START_TRIM = 2'b10,
    START_TRIM_UF = 2'b11
  } rtt_start_e;

  typedef enum logic [1:0] {
    CLK_FAST = 2'b00,
    CLK_SLOW = 2'b01,
    CLK_TMR0_UF = 2'b10,
    CLK_TMR1_UF = 2'b11
  } rtt_clk_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } rtt_run_e;

  typedef struct packed {
    logic [7:0] t3_ctrl;
    logic [15:0] t3_rld;
    logic [15:0] t3_cnt;
    rtt_run_e t3_st;
    logic t3_uf_p;
    logic [5:0] wk_ctrl;
    logic [15:0] wk_rld;
    logic [15:0] wk_cnt;
    rtt_run_e wk_st;
    logic [4:0] wk_pre;
    logic wake_p;
    logic low_power_card_detection_p;
    logic trim_p;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] prdata;
  } rtt_state_s;

endpackage : rtt_pkg

/* File: hw/rtt_timer3_wake.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
module rtt_timer3_wake (
  input wire logic pclk, // apb clock, 40 MHz
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic tick_fast, // 13.56 MHz count tick
  input wire logic tick_slow, // 211.875 kHz count tick
  input wire logic first_timer_uflow, // first timer underflow
  input wire logic second_timer_uflow, // second timer underflow
  input wire logic tx_end, // rf transmission ended
  input wire logic rx_first_bits, // first four bits received
  input wire logic trim_edge, // trim reference rising edge
  input wire logic lfo_tick, // low freq oscillator tick
  output logic timer_underflow, // general timer underflow pulse
  output logic timer_running, // general timer running
  output logic wake_request, // wake the system, pulse
  output logic card_detect_start, // launch card detection, pulse
  output logic trim_start, // launch oscillator trim, pulse
  output logic irq // level interrupt
);

  rtt_pkg::rtt_state_s s, n;
  rtt_pkg::rtt_start_e t3_mode;
  rtt_pkg::rtt_clk_e t3_clk;
  logic [6:0] idx;
  logic hit, wr, rd_setup, t3_trim, t3_tick, t3_start, t3_stop;
  logic t3_uflow, t3_hold, rx_stop, wk_tick, wk_uflow;
  logic [4:0] wk_tc;
  logic [7:0] rdval;

  assign idx = paddr[8:2];
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign t3_mode = rtt_pkg::rtt_start_e'(s.t3_ctrl[rtt_pkg::T3_START_LSB +: 2]);
  assign t3_clk = rtt_pkg::rtt_clk_e'(s.t3_ctrl[rtt_pkg::T3_CLK_LSB +: 2]);
  assign t3_trim = t3_mode[1];

  always_comb
  begin
    unique case (t3_clk)
      rtt_pkg::CLK_FAST: t3_tick = tick_fast;
      rtt_pkg::CLK_SLOW: t3_tick = tick_slow;
      rtt_pkg::CLK_TMR0_UF: t3_tick = first_timer_uflow;
      rtt_pkg::CLK_TMR1_UF: t3_tick = second_timer_uflow;
    endcase
  end

  // start/stop events of the general timer
  assign t3_start = (s.t3_st == rtt_pkg::ST_IDLE) &&
    ((t3_mode == rtt_pkg::START_TX_END && tx_end) ||
     (t3_trim && trim_edge));
  assign rx_stop = s.t3_ctrl[rtt_pkg::T3_STOP_RX_BIT] && !t3_trim &&
    rx_first_bits;
  assign t3_stop = (s.t3_st == rtt_pkg::ST_RUN) &&
    (rx_stop || (t3_trim && trim_edge));
  // trim without underflow parks at zero instead of underflowing
  assign t3_hold = t3_mode == rtt_pkg::START_TRIM;
  assign t3_uflow = (s.t3_st == rtt_pkg::ST_RUN) && !t3_stop && t3_tick &&
    s.t3_cnt == 16'h0000 && !t3_hold;

  always_comb
  begin
    unique case (s.wk_ctrl[rtt_pkg::WK_CLK_LSB +: 2])
      2'b00: wk_tc = rtt_pkg::WK_DIV1_TC;
      2'b01: wk_tc = rtt_pkg::WK_DIV8_TC;
      2'b10: wk_tc = rtt_pkg::WK_DIV16_TC;
      2'b11: wk_tc = rtt_pkg::WK_DIV32_TC;
    endcase
  end
  assign wk_tick = (s.wk_st == rtt_pkg::ST_RUN) && lfo_tick &&
    s.wk_pre == wk_tc;
  assign wk_uflow = wk_tick && s.wk_cnt == 16'h0000;

  always_comb
  begin
    hit = 1'b1;
    rdval = 8'h00;
    unique case (idx)
      rtt_pkg::IDX_T3_CTRL: rdval = s.t3_ctrl;
      rtt_pkg::IDX_T3_RLD_HI: rdval = s.t3_rld[15:8];
      rtt_pkg::IDX_T3_RLD_LO: rdval = s.t3_rld[7:0];
      rtt_pkg::IDX_T3_CNT_HI: rdval = s.t3_cnt[15:8];
      rtt_pkg::IDX_T3_CNT_LO: rdval = s.t3_cnt[7:0];
      rtt_pkg::IDX_WK_CTRL: rdval = {s.wk_st == rtt_pkg::ST_RUN, 1'b0,
                                     s.wk_ctrl};
      rtt_pkg::IDX_WK_RLD_HI: rdval = s.wk_rld[15:8];
      rtt_pkg::IDX_WK_RLD_LO: rdval = s.wk_rld[7:0];
      rtt_pkg::IDX_WK_CNT_HI: rdval = s.wk_cnt[15:8];
      rtt_pkg::IDX_WK_CNT_LO: rdval = s.wk_cnt[7:0];
      rtt_pkg::IDX_IRQ_STAT: rdval = {6'h00, s.irq_stat};
      rtt_pkg::IDX_IRQ_EN: rdval = {6'h00, s.irq_en};
      rtt_pkg::IDX_IRQ_CLR: rdval = 8'h00;
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    n = s;
    n.t3_uf_p = 1'b0;
    n.wake_p = 1'b0;
    n.low_power_card_detection_p = 1'b0;
    n.trim_p = 1'b0;
    if (rd_setup)
    begin
      n.prdata = {24'h000000, rdval};
    end
    // general timer
    if (t3_start)
    begin
      n.t3_cnt = s.t3_rld;
      n.t3_st = rtt_pkg::ST_RUN;
    end
    else if (t3_stop)
    begin
      n.t3_st = rtt_pkg::ST_IDLE;
    end
    else if (s.t3_st == rtt_pkg::ST_RUN && t3_tick)
    begin
      if (t3_uflow)
      begin
        n.t3_uf_p = 1'b1;
        if (s.t3_ctrl[rtt_pkg::T3_RESTART_BIT])
        begin
          n.t3_cnt = s.t3_rld;
        end
        else
        begin
          n.t3_st = rtt_pkg::ST_IDLE;
        end
      end
      else if (s.t3_cnt != 16'h0000)
      begin
        n.t3_cnt = s.t3_cnt - 16'h0001;
      end
    end
    // wake timer
    if (s.wk_st == rtt_pkg::ST_RUN && lfo_tick)
    begin
      n.wk_pre = wk_tick ? 5'h00 : s.wk_pre + 5'h01;
    end
    if (wk_tick)
    begin
      if (wk_uflow)
      begin
        n.wake_p = s.wk_ctrl[rtt_pkg::WK_WAKE_BIT];
        n.low_power_card_detection_p = s.wk_ctrl[rtt_pkg::WK_LOW_POWER_CARD_DETECTION_BIT];
        n.trim_p = s.wk_ctrl[rtt_pkg::WK_TRIM_BIT];
        if (s.wk_ctrl[rtt_pkg::WK_RESTART_BIT] ||
            s.wk_ctrl[rtt_pkg::WK_LOW_POWER_CARD_DETECTION_BIT])
        begin
          n.wk_cnt = s.wk_rld;
        end
        else
        begin
          n.wk_st = rtt_pkg::ST_IDLE;
        end
      end
      else
      begin
        n.wk_cnt = s.wk_cnt - 16'h0001;
      end
    end
    // register writes; reload bytes never touch a running count
    if (wr && hit)
    begin
      unique case (idx)
        rtt_pkg::IDX_T3_CTRL: n.t3_ctrl = pwdata[7:0] &
                                          rtt_pkg::T3_CTRL_WMASK;
        rtt_pkg::IDX_T3_RLD_HI: n.t3_rld[15:8] = pwdata[7:0];
        rtt_pkg::IDX_T3_RLD_LO: n.t3_rld[7:0] = pwdata[7:0];
        rtt_pkg::IDX_WK_CTRL:
        begin
          n.wk_ctrl = pwdata[5:0];
          if (pwdata[rtt_pkg::WK_RWE_BIT])
          begin
            n.wk_st = rtt_pkg::rtt_run_e'(pwdata[rtt_pkg::WK_RUN_BIT]);
            n.wk_cnt = pwdata[rtt_pkg::WK_RUN_BIT] ? s.wk_rld : n.wk_cnt;
            n.wk_pre = 5'h00;
          end
        end
        rtt_pkg::IDX_WK_RLD_HI: n.wk_rld[15:8] = pwdata[7:0];
        rtt_pkg::IDX_WK_RLD_LO: n.wk_rld[7:0] = pwdata[7:0];
        rtt_pkg::IDX_IRQ_EN: n.irq_en = pwdata[1:0];
        rtt_pkg::IDX_IRQ_CLR: n.irq_stat = s.irq_stat & ~pwdata[1:0];
        default: n.irq_en = s.irq_en;
      endcase
    end
    // set wins over a same-cycle clear
    if (t3_uflow)
    begin
      n.irq_stat[rtt_pkg::IRQ_T3_BIT] = 1'b1;
    end
    if (wk_uflow)
    begin
      n.irq_stat[rtt_pkg::IRQ_WK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '{t3_ctrl: rtt_pkg::T3_CTRL_RST, t3_rld: rtt_pkg::RLD_RST,
             t3_cnt: rtt_pkg::CNT_RST, t3_st: rtt_pkg::ST_IDLE,
             t3_uf_p: 1'b0, wk_ctrl: rtt_pkg::WK_CTRL_RST,
             wk_rld: rtt_pkg::RLD_RST, wk_cnt: rtt_pkg::CNT_RST,
             wk_st: rtt_pkg::ST_IDLE, wk_pre: 5'h00, wake_p: 1'b0,
             low_power_card_detection_p: 1'b0, trim_p: 1'b0, irq_stat: rtt_pkg::IRQ_RST,
             irq_en: rtt_pkg::IRQ_RST, prdata: 32'h00000000};
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign timer_underflow = s.t3_uf_p;
  assign timer_running = s.t3_st == rtt_pkg::ST_RUN;
  assign wake_request = s.wake_p;
  assign card_detect_start = s.low_power_card_detection_p;
  assign trim_start = s.trim_p;
  assign irq = |(s.irq_stat & s.irq_en);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic t3_idle;
  assign t3_idle = s.t3_st == rtt_pkg::ST_IDLE;

  a_rx_stop_halts: assert property (
    !t3_idle && rx_stop && !t3_start |=> t3_idle)
    else $error("timer kept running after receive stop");
  a_trim_ignores_rx: assert property (
    !t3_idle && t3_trim && rx_first_bits && !trim_edge && !t3_tick
    |=> !t3_idle)
    else $error("receive stop acted in trim mode");
  a_no_auto_start: assert property (
    t3_idle && t3_mode == rtt_pkg::START_OFF && !(wr && hit) |=> t3_idle)
    else $error("timer started in mode off");
  a_tx_start_load: assert property (
    t3_idle && t3_mode == rtt_pkg::START_TX_END && tx_end
    |=> !t3_idle && s.t3_cnt == $past(s.t3_rld))
    else $error("tx end start did not load reload value");
  a_trim_toggle: assert property (
    t3_trim && trim_edge && !(wr && hit) |=> t3_idle != $past(t3_idle))
    else $error("trim edge did not toggle the timer");
  a_auto_reload: assert property (
    t3_uflow && s.t3_ctrl[rtt_pkg::T3_RESTART_BIT]
    |=> !t3_idle && s.t3_cnt == $past(s.t3_rld))
    else $error("no reload at underflow");
  a_stop_at_zero: assert property (
    t3_uflow && !s.t3_ctrl[rtt_pkg::T3_RESTART_BIT]
    |=> t3_idle && s.t3_cnt == 16'h0000 ##1 (t3_idle || $past(t3_start)))
    else $error("timer did not stop at zero");
  a_uflow_flag: assert property (
    t3_uflow |=> s.irq_stat[rtt_pkg::IRQ_T3_BIT] && timer_underflow)
    else $error("underflow flag not set");
  a_decrement: assert property (
    !t3_idle && t3_tick && !t3_stop && s.t3_cnt != 16'h0000
    |=> s.t3_cnt == $past(s.t3_cnt) - 16'h0001)
    else $error("count did not decrement");
  a_cascade_hold: assert property (
    !t3_idle && t3_clk == rtt_pkg::CLK_TMR1_UF && !second_timer_uflow
    && !t3_stop |=> $stable(s.t3_cnt))
    else $error("count moved without selected tick");
  a_wake_run_write: assert property (
    wr && idx == rtt_pkg::IDX_WK_CTRL && !pwdata[rtt_pkg::WK_RWE_BIT]
    && !wk_uflow |=> $stable(s.wk_st))
    else $error("wake running changed without enable");
  a_wake_div: assert property (
    wk_tick |-> {1'b0, s.wk_pre} + 6'h01 ==
    (s.wk_ctrl[rtt_pkg::WK_CLK_LSB +: 2] == 2'b00 ? 6'h01 :
     6'h04 << s.wk_ctrl[rtt_pkg::WK_CLK_LSB +: 2]))
    else $error("wake prescaler divide ratio wrong");
  a_wake_prescale: assert property (
    s.wk_st == rtt_pkg::ST_RUN && lfo_tick && !wk_tick && !wr
    |=> s.wk_pre == $past(s.wk_pre) + 5'h01)
    else $error("wake prescaler did not advance");
  a_auto_wake: assert property (
    wk_uflow && s.wk_ctrl[rtt_pkg::WK_WAKE_BIT] |=> wake_request)
    else $error("no wake on wake timer underflow");
  a_card_detect: assert property (
    wk_uflow && s.wk_ctrl[rtt_pkg::WK_LOW_POWER_CARD_DETECTION_BIT] && !wr
    |=> card_detect_start && s.wk_st == rtt_pkg::ST_RUN)
    else $error("card detection not launched or timer stopped");
  a_wake_start_load: assert property (
    wr && idx == rtt_pkg::IDX_WK_CTRL && pwdata[rtt_pkg::WK_RWE_BIT] &&
    pwdata[rtt_pkg::WK_RUN_BIT]
    |=> s.wk_st == rtt_pkg::ST_RUN && s.wk_cnt == $past(s.wk_rld))
    else $error("wake timer run write did not start it");
  a_reload_no_touch: assert property (
    !t3_idle && wr && (idx == rtt_pkg::IDX_T3_RLD_HI ||
    idx == rtt_pkg::IDX_T3_RLD_LO) && !t3_tick && !t3_stop
    |=> $stable(s.t3_cnt))
    else $error("reload write changed running count");
  a_fast_hold: assert property (
    !t3_idle && t3_clk == rtt_pkg::CLK_FAST && !tick_fast && !t3_stop
    |=> $stable(s.t3_cnt))
    else $error("count moved without fast tick");
  a_slow_hold: assert property (
    !t3_idle && t3_clk == rtt_pkg::CLK_SLOW && !tick_slow && !t3_stop
    |=> $stable(s.t3_cnt))
    else $error("count moved without slow tick");
  a_first_cascade: assert property (
    !t3_idle && t3_clk == rtt_pkg::CLK_TMR0_UF && !first_timer_uflow
    && !t3_stop
    |=> $stable(s.t3_cnt))
    else $error("count moved without first timer underflow");
  a_trim_park: assert property (
    !t3_idle && t3_mode == rtt_pkg::START_TRIM && t3_tick &&
    s.t3_cnt == 16'h0000 && !trim_edge
    |=> !t3_idle && s.t3_cnt == 16'h0000 && !timer_underflow)
    else $error("trim without underflow did not park at zero");

  c_tx_start: cover property (t3_idle && tx_end ##1 !t3_idle);
  c_reload: cover property (t3_uflow &&
    s.t3_ctrl[rtt_pkg::T3_RESTART_BIT] ##1 !t3_idle);
  c_rx_stop: cover property (rx_stop && !t3_idle ##1 t3_idle);
  c_wake: cover property (wake_request && card_detect_start);

endmodule : rtt_timer3_wake

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] ev = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_underflow;
  logic timer_running;
  logic wake_request;
  logic card_detect_start;
  logic trim_start;
  logic irq;
  logic err;
  logic [31:0] q;
  logic [7:0] m_ctrl = 8'h00;
  logic [15:0] m_rld = 16'h0000;
  logic [1:0] m_stat = 2'h0;
  logic [1:0] m_en = 2'h0;
  logic m_run = 1'b0;
  int m_cnt = 0;
  int m_uf = 0;
  int uf_seen = 0;
  int wk_seen = 0;
  int cd_seen = 0;
  int tr_seen = 0;
  int fails = 0;
  int checked = 0;
  int seed = 32'h53f2101b;

  always #12.5 pclk = ~pclk;

  rtt_timer3_wake u_rtt_timer3_wake (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_fast(ev[0]),
    .tick_slow(ev[1]), .first_timer_uflow(ev[2]),
    .second_timer_uflow(ev[3]), .tx_end(ev[4]), .rx_first_bits(ev[5]),
    .trim_edge(ev[6]), .lfo_tick(ev[7]),
    .timer_underflow(timer_underflow), .timer_running(timer_running),
    .wake_request(wake_request), .card_detect_start(card_detect_start),
    .trim_start(trim_start), .irq(irq)
  );

  // pulse outputs counted at the edge that sees them
  always @(posedge pclk)
  begin
    if (timer_underflow === 1'b1) uf_seen++;
    if (wake_request === 1'b1) wk_seen++;
    if (card_detect_start === 1'b1) cd_seen++;
    if (trim_start === 1'b1) tr_seen++;
  end

  task automatic test_done();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [6:0] idx,
                     input logic [7:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      fails++;
      test_done();
    end
    else
    begin
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] r;
    case (idx)
      rtt_pkg::IDX_T3_CTRL: m_ctrl = d & rtt_pkg::T3_CTRL_WMASK;
      rtt_pkg::IDX_T3_RLD_HI: m_rld[15:8] = d;
      rtt_pkg::IDX_T3_RLD_LO: m_rld[7:0] = d;
      rtt_pkg::IDX_IRQ_EN: m_en = d[1:0];
      rtt_pkg::IDX_IRQ_CLR: m_stat = m_stat & ~d[1:0];
      default: ;
    endcase
    apb(1'b1, idx, d, r);
  endtask : wr

  task automatic rd(input string nm, input logic [6:0] idx,
                    input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, idx, 8'h00, r);
    chk(nm, e, r);
  endtask : rd

  // model of the general timer, then one pulse on the chosen input
  task automatic pulse(input int b);
    logic [1:0] md;
    md = m_ctrl[5:4];
    if (!m_run)
    begin
      if ((md == 2'b01 && b == 4) || (md[1] && b == 6))
      begin
        m_run = 1'b1;
        m_cnt = m_rld;
      end
    end
    else if (md[1] && b == 6)
      m_run = 1'b0;
    else if (b == 5 && m_ctrl[7] && !md[1])
      m_run = 1'b0;
    else if (b == int'(m_ctrl[1:0]))
    begin
      if (m_cnt != 0)
        m_cnt--;
      else if (md != 2'b10)
      begin
        m_uf++;
        m_stat[0] = 1'b1;
        if (!m_ctrl[3])
          m_run = 1'b0;
        else
          m_cnt = m_rld;
      end
    end
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
  endtask : pulse

  task automatic chk_all();
    repeat (2) @(posedge pclk);
    chk("running", {31'h0, m_run}, {31'h0, timer_running});
    chk("underflows", m_uf, uf_seen);
    chk("irq", {31'h0, |(m_stat & m_en)}, {31'h0, irq});
    rd("count_high", rtt_pkg::IDX_T3_CNT_HI, m_cnt[15:8]);
    rd("count_low", rtt_pkg::IDX_T3_CNT_LO, m_cnt[7:0]);
    rd("irq_status", rtt_pkg::IDX_IRQ_STAT, {30'h0, m_stat});
  endtask : chk_all

  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 30; i <= 41; i++)
      rd("reset_value", 7'(i), 32'h00000000);
    apb(1'b1, 7'h10, 8'hff, q);
    chk("unmapped_wr_err", 32'h1, {31'h0, err});
    apb(1'b0, 7'h10, 8'h00, q);
    chk("unmapped_rd_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, q);
    wr(rtt_pkg::IDX_T3_CTRL, 8'($random(seed)));
    rd("control", rtt_pkg::IDX_T3_CTRL, m_ctrl);
    apb(1'b1, rtt_pkg::IDX_T3_CNT_LO, 8'($random(seed)), q);
    wr(rtt_pkg::IDX_T3_CTRL, 8'h00);
    wr(rtt_pkg::IDX_T3_RLD_HI, 8'h00);
    wr(rtt_pkg::IDX_T3_RLD_LO, 8'h03);
    wr(rtt_pkg::IDX_IRQ_EN, 8'h01);
    pulse(4);
    chk_all();
    wr(rtt_pkg::IDX_T3_CTRL, 8'h10);
    pulse(4);
    chk_all();
    wr(rtt_pkg::IDX_T3_RLD_LO, 8'h09);
    repeat (5) pulse(0);
    chk_all();
    wr(rtt_pkg::IDX_IRQ_EN, 8'h00);
    chk_all();
    wr(rtt_pkg::IDX_IRQ_EN, 8'h01);
    wr(rtt_pkg::IDX_IRQ_CLR, 8'h01);
    chk_all();
    wr(rtt_pkg::IDX_T3_RLD_LO, 8'h02);
    for (int c = 0; c < 4; c++)
    begin
      wr(rtt_pkg::IDX_T3_CTRL, 8'h98 | 8'(c));
      pulse(4);
      repeat (2) pulse((c + 1) % 4);
      repeat (4) pulse(c);
      chk_all();
      pulse(5);
      chk_all();
    end
    wr(rtt_pkg::IDX_T3_CTRL, 8'hb8);
    pulse(6);
    pulse(5);
    repeat (2) pulse(0);
    chk_all();
    pulse(6);
    chk_all();
    wr(rtt_pkg::IDX_T3_CTRL, 8'h20);
    pulse(6);
    repeat (4) pulse(0);
    chk_all();
    pulse(6);
    chk_all();
    wr(rtt_pkg::IDX_IRQ_CLR, 8'h03);
    apb(1'b1, rtt_pkg::IDX_WK_RLD_LO, 8'h01, q);
    apb(1'b1, rtt_pkg::IDX_WK_CTRL, 8'h80, q);
    rd("wake_ctrl", rtt_pkg::IDX_WK_CTRL, 32'h00);
    apb(1'b1, rtt_pkg::IDX_WK_CTRL, 8'hd5, q);
    rd("wake_ctrl", rtt_pkg::IDX_WK_CTRL, 32'h95);
    repeat (20) pulse(7);
    repeat (2) @(posedge pclk);
    chk("wake_pulses", 32'd1, wk_seen);
    chk("detect_pulses", 32'd1, cd_seen);
    chk("trim_pulses", 32'd0, tr_seen);
    rd("wake_ctrl", rtt_pkg::IDX_WK_CTRL, 32'h95);
    rd("irq_status", rtt_pkg::IDX_IRQ_STAT, 32'h02);
    apb(1'b1, rtt_pkg::IDX_WK_CTRL, 8'h55, q);
    rd("wake_ctrl", rtt_pkg::IDX_WK_CTRL, 32'h15);
    apb(1'b1, rtt_pkg::IDX_WK_CTRL, 8'he4, q);
    repeat (4) pulse(7);
    repeat (2) @(posedge pclk);
    chk("wake_pulses", 32'd2, wk_seen);
    chk("detect_pulses", 32'd1, cd_seen);
    chk("trim_pulses", 32'd1, tr_seen);
    rd("wake_ctrl", rtt_pkg::IDX_WK_CTRL, 32'h24);
    rd("wake_count", rtt_pkg::IDX_WK_CNT_LO, 32'h00);
    test_done();
  end
endmodule : tb_top
